//--- design/tsme_pkg.sv
/*
  Package for the timer slave mode controller and encoder interface:
  mode codes, trigger select codes, widths, reset values and the
  carrier structs for configuration and module state.
  Assumes one kernel clock and a synchronous active-low reset.
*/
package tsme_pkg;

  // ==========================================================
  // Widths and counts
  localparam int unsigned TSME_CNT_W  = 16;
  localparam int unsigned TSME_SYNC_N = 4;  // three timer inputs plus trigger pin
  localparam int unsigned TSME_ETR_W  = 3;

  // Sync vector bit positions
  localparam int unsigned TSME_B_IN1 = 0;
  localparam int unsigned TSME_B_IN2 = 1;
  localparam int unsigned TSME_B_IN3 = 2;
  localparam int unsigned TSME_B_ETR = 3;

  // ==========================================================
  // Slave mode codes
  typedef enum logic [2:0] {
    TSME_SM_OFF   = 3'h0,
    TSME_SM_ENC1  = 3'h1,
    TSME_SM_ENC2  = 3'h2,
    TSME_SM_ENC3  = 3'h3,
    TSME_SM_RESET = 3'h4,
    TSME_SM_GATED = 3'h5,
    TSME_SM_TRIG  = 3'h6,
    TSME_SM_EXT1  = 3'h7
  } tsme_smode_e;

  // Trigger select codes
  typedef enum logic [2:0] {
    TSME_TS_INTERNAL_TRIGGER_0 = 3'h0,
    TSME_TS_INTERNAL_TRIGGER_1 = 3'h1,
    TSME_TS_INTERNAL_TRIGGER_2 = 3'h2,
    TSME_TS_INTERNAL_TRIGGER_3 = 3'h3,
    TSME_TS_ED1  = 3'h4,
    TSME_TS_FP1  = 3'h5,
    TSME_TS_FP2  = 3'h6,
    TSME_TS_ETRF = 3'h7
  } tsme_tsel_e;

  // ==========================================================
  // Software configuration carried as one bundle
  typedef struct packed {
    tsme_smode_e           slave_mode_select;
    tsme_tsel_e            trigger_select;
    logic                  input_one_polarity;
    logic                  input_two_polarity;
    logic                  xor_select;
    logic                  ext_trigger_polarity;
    logic [1:0]            ext_trigger_prescaler;
    logic                  ext_clock2_enable;
    logic                  update_request_source;
    logic                  trigger_irq_enable;
    logic                  trigger_dma_enable;
    logic [TSME_CNT_W-1:0] auto_reload_value;
    logic [TSME_CNT_W-1:0] counter_prescaler;
  } tsme_cfg_s;

  // All module state
  typedef struct packed {
    logic [TSME_SYNC_N-1:0] sync1;
    logic [TSME_SYNC_N-1:0] sync2;
    logic                   fp1_prev;
    logic                   fp2_prev;
    logic                   etr_prev;
    logic                   trig_prev;
    logic [TSME_ETR_W-1:0]  etr_cnt;
    logic [TSME_CNT_W-1:0]  psc_cnt;
    logic [TSME_CNT_W-1:0]  psc_act;
    logic [TSME_CNT_W-1:0]  arr_act;
    logic [TSME_CNT_W-1:0]  cnt;
    logic                   dir_down;
    logic                   counter_enable_bit;
    logic                   tflag;
    logic                   tirq;
    logic                   tdma;
    logic                   upd;
  } tsme_state_s;

  // ==========================================================
  // Reset values
  localparam tsme_state_s     TSME_STATE_RST = '0;
  localparam logic [TSME_CNT_W-1:0] TSME_CNT_ZERO = '0;

endpackage : tsme_pkg

//--- design/tsme_top.sv
/*
  Slave mode controller and incremental encoder interface of one
  general-purpose timer instance. Holds the counter, its prescaler,
  trigger routing and the trigger flag.
  Assumes configuration bits come from a register file elsewhere,
  internal triggers come from sibling instances on the same clock,
  and timer inputs and the trigger pin are asynchronous pins.
*/
// Summary of operation
// - Mode 001 counts first-input edges, 010 second-input, 011 both.
// - Encoder counter wraps between zero and the reload value both ways.
// - Prescaler and counter outputs behave the same in encoder mode.
// - Encoder steps once per valid filtered edge, only while enabled.
// - First-input edge: rise down, fall up if second high; else reversed.
// - Second-input edge: rise up, fall down if first high; else reversed.
// - Encoder mode overrides external clock mode 2.
// - Codes 000..011 pick internal triggers routed per instance table.
// - Reset mode trigger clears counter and prescaler, counting continues.
// - Reset trigger with update source low raises update, loads preloads.
// - Trigger event in reset, trigger or external clock 1 mode sets flag, interrupt and DMA request when enabled.
// - Trigger select 101 picks filtered first input, 110 the second.
// - Timer inputs and trigger pin are resynchronised before acting, adding fixed delay; internal triggers are not.
// - Gated mode counts only while trigger level active; polarity inverts.
// - Gated mode sets the trigger flag on both start and stop.
// - Trigger mode edge sets the counter enable and the flag.
// - External clock 2 clocks counter alongside reset, gated, trigger.
// - Trigger pin prescaler 00 divides by one, polarity 0 rising edges.
// - XOR of three timer inputs can replace the first input in all its uses.
`timescale 1ns/100ps
`default_nettype none

module tsme_top
  import tsme_pkg::*;
#(
  parameter int unsigned INSTANCE_ID = 3   // Which sibling table row applies
) (
  input  wire logic                            i_ref_clk,      // Kernel clock
  input  wire logic                            i_rst_b,        // Sync reset, low
  input  wire tsme_pkg::tsme_cfg_s             i_cfg,          // Software config
  input  wire logic                            i_cen_set,      // Enable pulse
  input  wire logic                            i_cen_clr,      // Disable pulse
  input  wire logic                            i_flag_clr,     // Flag clear pulse
  input  wire logic                            i_timer_input_one,  // Pin
  input  wire logic                            i_timer_input_two,  // Pin
  input  wire logic                            i_timer_input_three, // Pin
  input  wire logic                            i_external_trigger_pin, // Pin
  input  wire logic                            i_trig_inst3,   // Sibling trigger
  input  wire logic                            i_trig_inst4,   // Sibling trigger
  input  wire logic                            i_trig_inst5,   // Sibling trigger
  output logic [tsme_pkg::TSME_CNT_W-1:0]      o_count,        // Counter value
  output logic                                 o_dir_down,     // Down direction
  output logic                                 o_counter_enable, // Enable state
  output logic                                 o_trigger_flag, // Sticky flag
  output logic                                 o_trigger_irq,  // Interrupt req
  output logic                                 o_trigger_dma,  // DMA req pulse
  output logic                                 o_update_event  // Update pulse
);
  import tsme_pkg::*;

  // ==========================================================
  // Helpers

  // Internal trigger routing; reserved slots read low
  function automatic logic route_itr(input logic [2:0] code, input logic t3,
                                     input logic t4, input logic t5);
    logic r;
    r = 1'b0;
    if (INSTANCE_ID == 3) begin
      if (code == TSME_TS_INTERNAL_TRIGGER_0) r = t5;
      else if (code == TSME_TS_INTERNAL_TRIGGER_2) r = t4;
    end else if (INSTANCE_ID == 4) begin
      if (code == TSME_TS_INTERNAL_TRIGGER_1) r = t3;
      else if (code == TSME_TS_INTERNAL_TRIGGER_2) r = t5;
    end else begin
      if (code == TSME_TS_INTERNAL_TRIGGER_1) r = t3;
      else if (code == TSME_TS_INTERNAL_TRIGGER_2) r = t4;
    end
    return r;
  endfunction : route_itr

  // Divide ratio of the trigger pin prescaler, minus one
  function automatic logic [TSME_ETR_W-1:0] etr_div(input logic [1:0] pre);
    return TSME_ETR_W'((1 << pre) - 1);
  endfunction : etr_div

  tsme_state_s st_q;
  tsme_state_s st_d;

  logic                  in1_src;
  logic                  fp1;
  logic                  fp2;
  logic                  etrp;
  logic                  fp1_rise;
  logic                  fp1_fall;
  logic                  fp2_rise;
  logic                  fp2_fall;
  logic                  is_enc;
  logic                  enc_a;
  logic                  enc_b;
  logic                  enc_step;
  logic                  enc_down;
  logic                  etr_edge;
  logic                  etr_tick;
  logic                  trig_sig;
  logic                  trig_evt;
  logic                  gate_chg;
  logic                  tick;
  logic                  run;
  logic                  psc_wrap;
  logic                  rst_trig;
  logic                  flag_set;

  // ==========================================================
  // Input conditioning, after the synchroniser's second stage
  always_comb begin
    in1_src  = st_q.sync2[TSME_B_IN1];
    if (i_cfg.xor_select) begin
      in1_src = st_q.sync2[TSME_B_IN1] ^ st_q.sync2[TSME_B_IN2]
              ^ st_q.sync2[TSME_B_IN3];
    end
    fp1      = in1_src ^ i_cfg.input_one_polarity;
    fp2      = st_q.sync2[TSME_B_IN2] ^ i_cfg.input_two_polarity;
    etrp     = st_q.sync2[TSME_B_ETR] ^ i_cfg.ext_trigger_polarity;
    fp1_rise = fp1 & ~st_q.fp1_prev;
    fp1_fall = ~fp1 & st_q.fp1_prev;
    fp2_rise = fp2 & ~st_q.fp2_prev;
    fp2_fall = ~fp2 & st_q.fp2_prev;
  end

  // Encoder decode; inputs assumed not to switch together
  always_comb begin
    is_enc   = (i_cfg.slave_mode_select == TSME_SM_ENC1)
             | (i_cfg.slave_mode_select == TSME_SM_ENC2)
             | (i_cfg.slave_mode_select == TSME_SM_ENC3);
    enc_a    = (fp1_rise | fp1_fall) & (i_cfg.slave_mode_select != TSME_SM_ENC2);
    enc_b    = (fp2_rise | fp2_fall) & (i_cfg.slave_mode_select != TSME_SM_ENC1);
    enc_step = is_enc & (enc_a | enc_b);
    enc_down = st_q.dir_down;
    if (enc_a) begin
      enc_down = (fp1 == fp2);
    end else if (enc_b) begin
      enc_down = (fp1 != fp2);
    end
  end

  // Trigger source and trigger pin divider
  always_comb begin
    etr_edge = etrp & ~st_q.etr_prev;
    etr_tick = etr_edge & (st_q.etr_cnt == etr_div(i_cfg.ext_trigger_prescaler));
    case (i_cfg.trigger_select)
      TSME_TS_ED1:  trig_sig = fp1_rise | fp1_fall;
      TSME_TS_FP1:  trig_sig = fp1;
      TSME_TS_FP2:  trig_sig = fp2;
      TSME_TS_ETRF: trig_sig = etrp;
      default:      trig_sig = route_itr(i_cfg.trigger_select, i_trig_inst3,
                                         i_trig_inst4, i_trig_inst5);
    endcase
    // Edge detector source already pulses once per edge
    trig_evt = (i_cfg.trigger_select == TSME_TS_ED1) ? trig_sig
             : (trig_sig & ~st_q.trig_prev);
    gate_chg = trig_sig ^ st_q.trig_prev;
  end

  // Counter clock selection; encoder first, so clock 2 yields to it
  always_comb begin
    if (is_enc) begin
      tick = enc_step;
    end else if (i_cfg.slave_mode_select == TSME_SM_EXT1) begin
      tick = trig_evt;
    end else if (i_cfg.ext_clock2_enable) begin
      tick = etr_tick;
    end else begin
      tick = 1'b1;
    end
    run = st_q.counter_enable_bit & ((i_cfg.slave_mode_select != TSME_SM_GATED) | trig_sig);
    psc_wrap = run & tick & (st_q.psc_cnt == st_q.psc_act);
    rst_trig = (i_cfg.slave_mode_select == TSME_SM_RESET) & trig_evt;
    flag_set = trig_evt & ((i_cfg.slave_mode_select == TSME_SM_RESET)
                         | (i_cfg.slave_mode_select == TSME_SM_TRIG)
                         | (i_cfg.slave_mode_select == TSME_SM_EXT1));
    if (i_cfg.slave_mode_select == TSME_SM_GATED) begin
      flag_set = st_q.counter_enable_bit & gate_chg;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d           = st_q;
    st_d.sync1     = {i_external_trigger_pin, i_timer_input_three,
                      i_timer_input_two, i_timer_input_one};
    st_d.sync2     = st_q.sync1;
    st_d.fp1_prev  = fp1;
    st_d.fp2_prev  = fp2;
    st_d.etr_prev  = etrp;
    st_d.trig_prev = trig_sig;
    st_d.upd       = 1'b0;
    st_d.tdma      = 1'b0;

    // Trigger pin divider counts polarity-selected rising edges
    if (etr_tick) begin
      st_d.etr_cnt = '0;
    end else if (etr_edge) begin
      st_d.etr_cnt = st_q.etr_cnt + TSME_ETR_W'(1);
    end

    // Enable: trigger mode start or software set beat a clear
    if (i_cen_clr) st_d.counter_enable_bit = 1'b0;
    if (i_cen_set) st_d.counter_enable_bit = 1'b1;
    if (i_cfg.slave_mode_select == TSME_SM_TRIG && trig_evt) begin
      st_d.counter_enable_bit = 1'b1;
    end

    if (is_enc && enc_step && st_q.counter_enable_bit) begin
      st_d.dir_down = enc_down;
    end

    // Prescaler and counter; same path serves every mode
    if (rst_trig) begin
      st_d.psc_cnt = '0;
      st_d.cnt     = TSME_CNT_ZERO;
      st_d.upd     = ~i_cfg.update_request_source;
    end else if (psc_wrap) begin
      st_d.psc_cnt = '0;
      if (is_enc && enc_down) begin
        if (st_q.cnt == TSME_CNT_ZERO) begin
          st_d.cnt = st_q.arr_act;
          st_d.upd = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt - TSME_CNT_W'(1);
        end
      end else begin
        if (st_q.cnt == st_q.arr_act) begin
          st_d.cnt = TSME_CNT_ZERO;
          st_d.upd = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + TSME_CNT_W'(1);
        end
      end
    end else if (run && tick) begin
      st_d.psc_cnt = st_q.psc_cnt + TSME_CNT_W'(1);
    end

    // Update event moves preloads into the active copies
    if (st_d.upd) begin
      st_d.arr_act = i_cfg.auto_reload_value;
      st_d.psc_act = i_cfg.counter_prescaler;
    end

    // Flag: a new event wins over a clear in the same cycle
    if (i_flag_clr) st_d.tflag = 1'b0;
    if (flag_set) begin
      st_d.tflag = 1'b1;
      st_d.tdma  = i_cfg.trigger_dma_enable;
    end
    st_d.tirq = st_d.tflag & i_cfg.trigger_irq_enable;
  end

  // State register, synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_q <= TSME_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign o_count          = st_q.cnt;
  assign o_dir_down       = st_q.dir_down;
  assign o_counter_enable = st_q.counter_enable_bit;
  assign o_trigger_flag   = st_q.tflag;
  assign o_trigger_irq    = st_q.tirq;
  assign o_trigger_dma    = st_q.tdma;
  assign o_update_event   = st_q.upd;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  property p_enc_wrap_up;
    psc_wrap && is_enc && !enc_down && !rst_trig && st_q.cnt == st_q.arr_act
      |=> st_q.cnt == TSME_CNT_ZERO && st_q.upd;
  endproperty
  a_enc_wrap_up: assert property (p_enc_wrap_up) else $error("no wrap to zero");

  property p_enc_wrap_dn;
    psc_wrap && is_enc && enc_down && !rst_trig && st_q.cnt == TSME_CNT_ZERO
      |=> st_q.cnt == $past(st_q.arr_act);
  endproperty
  a_enc_wrap_dn: assert property (p_enc_wrap_dn) else $error("no wrap to reload");

  property p_enc_hold;
    is_enc && !st_q.counter_enable_bit && !rst_trig |=> $stable(st_q.cnt);
  endproperty
  a_enc_hold: assert property (p_enc_hold) else $error("encoder moved while off");

  property p_dir_one;
    st_q.counter_enable_bit && is_enc && enc_a && fp1_rise && fp2 |=> st_q.dir_down;
  endproperty
  a_dir_one: assert property (p_dir_one) else $error("first input dir wrong");

  property p_dir_two;
    st_q.counter_enable_bit && is_enc && enc_b && fp2_rise && fp1 |=> !st_q.dir_down;
  endproperty
  a_dir_two: assert property (p_dir_two) else $error("second input dir wrong");

  property p_reset_mode;
    rst_trig |=> st_q.cnt == TSME_CNT_ZERO && st_q.psc_cnt == TSME_CNT_ZERO
      && st_q.upd == !$past(i_cfg.update_request_source);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset trigger missed");

  property p_flag_irq;
    flag_set |=> st_q.tflag && st_q.tirq == $past(i_cfg.trigger_irq_enable);
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag or irq wrong");

  property p_gate_stop;
    i_cfg.slave_mode_select == TSME_SM_GATED && !trig_sig |=> $stable(st_q.psc_cnt)
      || st_q.psc_cnt == TSME_CNT_ZERO;
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("gate leaked count");

  property p_trig_start;
    i_cfg.slave_mode_select == TSME_SM_TRIG && trig_evt |=> st_q.counter_enable_bit && st_q.tflag;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger start missed");

  property p_sync_delay;
    $rose(i_timer_input_one) && !i_cfg.xor_select |-> ##2 st_q.sync2[TSME_B_IN1];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

endmodule : tsme_top

`default_nettype wire

//--- tb/test_tsme_top.sv
/*
  Self-checking bench for the timer slave mode controller.
  Assumes the encoder model in tsme_enc_model.sv and instance id 3.
*/
`timescale 1ns/100ps
`default_nettype none

module test_tsme_top;
  import tsme_pkg::*;

  typedef struct {
    int          sel;
    logic [15:0] exp;
  } tsme_note_s;

  // ==========================================================
  // Signals
  localparam logic [15:0] ARR_V = 16'h0005;
  logic        ref_clk = 1'b0;
  logic        rst_b, cen_set, cen_clr, flag_clr, pin3, external_trigger_pin, chk_go, hit, down, cnt_on;
  logic [2:0]  sib;
  tsme_cfg_s   cfg;
  logic [15:0] count, exp_cnt;
  logic        pin_a, pin_b, dir_down, counter_enable_bit, flag, irq, dma, upd;
  int          error_cnt, checks_done, upd_cnt, dma_cnt;
  tsme_note_s  q[$];
  string       names[7] = '{"count", "enable", "flag", "irq", "updates", "dma", "dir"};

  always #2 ref_clk = ~ref_clk;

  tsme_top #(.INSTANCE_ID(3)) tsme_top_i (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_cfg(cfg), .i_cen_set(cen_set),
    .i_cen_clr(cen_clr), .i_flag_clr(flag_clr), .i_timer_input_one(pin_a),
    .i_timer_input_two(pin_b), .i_timer_input_three(pin3), .i_external_trigger_pin(external_trigger_pin),
    .i_trig_inst3(sib[0]), .i_trig_inst4(sib[1]), .i_trig_inst5(sib[2]),
    .o_count(count), .o_dir_down(dir_down), .o_counter_enable(counter_enable_bit), .o_trigger_flag(flag),
    .o_trigger_irq(irq), .o_trigger_dma(dma), .o_update_event(upd));

  tsme_enc_model enc_i (.i_ref_clk(ref_clk), .o_pin_a(pin_a), .o_pin_b(pin_b));

  // ==========================================================
  // Monitor: tallies one-cycle pulses, compares the oldest note
  // Falling edge keeps it clear of the edge that launches the outputs
  always @(negedge ref_clk) begin
    tsme_note_s  n;
    logic [15:0] act;
    if (upd === 1'b1) upd_cnt++;
    if (dma === 1'b1) dma_cnt++;
    if (chk_go === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      case (n.sel)
        0: act = count;
        1: act = {15'h0000, counter_enable_bit};
        2: act = {15'h0000, flag};
        3: act = {15'h0000, irq};
        4: act = 16'(upd_cnt);
        5: act = 16'(dma_cnt);
        default: act = {15'h0000, dir_down};
      endcase
      checks_done++;
      if (act !== n.exp) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %0h seen %0h", names[n.sel], n.exp, act);
      end
    end
  end

  // ==========================================================
  // Tasks
  task automatic note(input int sel, input logic [15:0] exp);
    q.push_back('{sel, exp});
    @(posedge ref_clk);
    chk_go <= 1'b1;
    @(posedge ref_clk);
    chk_go <= 1'b0;
  endtask : note

  task automatic ctl(input logic s, input logic c, input logic f);
    @(posedge ref_clk);
    cen_set  <= s;
    cen_clr  <= c;
    flag_clr <= f;
    @(posedge ref_clk);
    cen_set  <= 1'b0;
    cen_clr  <= 1'b0;
    flag_clr <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : ctl

  task automatic etr_pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      external_trigger_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      external_trigger_pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask : etr_pulses

  // Random shaft step; the trigger pin toggles too, which must not count
  task automatic enc_step(input int m, input logic en);
    logic a0;
    a0 = pin_a;
    enc_i.step(1'($urandom_range(0, 1)), $urandom_range(0, 3));
    external_trigger_pin <= 1'($urandom_range(0, 1));
    repeat (2) @(posedge ref_clk);
    cnt_on = en && ((pin_a !== a0) ? (m != 2) : (m != 1));
    down = (pin_a == pin_b) ^ (pin_a === a0);
    if (cnt_on) begin
      if (down) exp_cnt = (exp_cnt == 16'h0000) ? ARR_V : exp_cnt - 16'h0001;
      else exp_cnt = (exp_cnt == ARR_V) ? 16'h0000 : exp_cnt + 16'h0001;
      note(6, {15'h0000, down});
    end
    note(0, exp_cnt);
  endtask : enc_step

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // ==========================================================
  // Watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(37));
    {rst_b, cen_set, cen_clr, flag_clr, pin3, external_trigger_pin, chk_go, sib} = '0;
    cfg = '0;
    cfg.auto_reload_value = ARR_V;
    cfg.counter_prescaler = 16'h0000;
    cfg.trigger_irq_enable = 1'b1;
    cfg.trigger_dma_enable = 1'b1;
    cfg.slave_mode_select = TSME_SM_RESET;
    cfg.trigger_select = TSME_TS_FP1;
    exp_cnt = 16'h0000;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Reset trigger with the counter stopped: update and requests
    enc_i.set_pins(1'b1, 1'b0);
    note(4, 16'h0001);
    note(2, 16'h0001);
    note(3, 16'h0001);
    note(5, 16'h0001);
    ctl(1'b0, 1'b0, 1'b1);
    cfg.update_request_source <= 1'b1;
    enc_i.set_pins(1'b0, 1'b0);
    enc_i.set_pins(1'b1, 1'b0);
    note(4, 16'h0001);
    note(5, 16'h0002);
    // Encoder modes, then the same shaft with the enable off
    cfg.ext_clock2_enable <= 1'b1;
    for (int m = 1; m <= 3; m++) begin
      cfg.slave_mode_select <= tsme_smode_e'(m);
      ctl(1'b1, 1'b0, 1'b0);
      repeat (24) enc_step(m, 1'b1);
      ctl(1'b0, 1'b1, 1'b0);
      repeat (4) enc_step(m, 1'b0);
    end
    // Trigger mode fed from each sibling on each internal slot
    cfg.slave_mode_select <= TSME_SM_TRIG;
    cfg.ext_clock2_enable <= 1'b0;
    external_trigger_pin <= 1'b0; // Random shaft phase may have left the pin high
    for (int t = 0; t < 4; t++) begin
      for (int s = 0; s < 3; s++) begin
        cfg.trigger_select <= tsme_tsel_e'(t);
        ctl(1'b0, 1'b1, 1'b1);
        sib <= 3'(1 << s);
        repeat (6) @(posedge ref_clk);
        hit = (t == 0 && s == 2) || (t == 2 && s == 1);
        note(1, {15'h0000, hit});
        note(2, {15'h0000, hit});
        sib <= 3'h0;
        repeat (4) @(posedge ref_clk);
      end
    end
    // Three-input combination as trigger, then second filtered input
    cfg.trigger_select <= TSME_TS_ED1;
    cfg.xor_select <= 1'b1;
    ctl(1'b0, 1'b1, 1'b1);
    pin3 <= 1'b1;
    repeat (6) @(posedge ref_clk);
    note(1, 16'h0001);
    cfg.trigger_select <= TSME_TS_FP2;
    cfg.xor_select <= 1'b0;
    enc_i.set_pins(1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b1);
    enc_i.set_pins(1'b0, 1'b1);
    note(1, 16'h0001);
    note(2, 16'h0001);
    // Trigger pin clocking with reset mode, trigger stays off the pin
    cfg.slave_mode_select <= TSME_SM_RESET;
    cfg.trigger_select <= TSME_TS_FP1;
    cfg.ext_clock2_enable <= 1'b1;
    enc_i.set_pins(1'b0, 1'b0);
    enc_i.set_pins(1'b1, 1'b0);
    etr_pulses(3);
    note(0, 16'h0003);
    enc_i.set_pins(1'b0, 1'b0);
    enc_i.set_pins(1'b1, 1'b0);
    note(0, 16'h0000);
    // Gated with inverted polarity: high pin closes the gate
    cfg.slave_mode_select <= TSME_SM_GATED;
    cfg.input_one_polarity <= 1'b1;
    ctl(1'b0, 1'b0, 1'b1);
    etr_pulses(2);
    note(0, 16'h0000);
    enc_i.set_pins(1'b0, 1'b0);
    note(2, 16'h0001);
    etr_pulses(1);
    note(0, 16'h0001);
    ctl(1'b0, 1'b0, 1'b1);
    enc_i.set_pins(1'b1, 1'b0);
    note(2, 16'h0001);
    // External clock 1 from the trigger pin, then clock 2 divided by two
    cfg.slave_mode_select <= TSME_SM_EXT1;
    cfg.trigger_select <= TSME_TS_ETRF;
    cfg.ext_clock2_enable <= 1'b0;
    ctl(1'b0, 1'b0, 1'b1);
    etr_pulses(2);
    note(0, 16'h0003);
    note(2, 16'h0001);
    cfg.slave_mode_select <= TSME_SM_RESET;
    cfg.trigger_select <= TSME_TS_FP1;
    cfg.ext_clock2_enable <= 1'b1;
    cfg.ext_trigger_prescaler <= 2'h1;
    etr_pulses(4);
    note(0, 16'h0005);
    repeat (4) @(posedge ref_clk);
    conclude();
  end

endmodule : test_tsme_top

`default_nettype wire

//--- tb/tsme_enc_model.sv
/*
  Quadrature encoder model that drives the two timer input pins.
  Assumes it is stepped from the kernel clock domain by the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module tsme_enc_model (
  input  wire logic i_ref_clk, // Kernel clock
  output var  logic o_pin_a,   // Channel A
  output var  logic o_pin_b    // Channel B
);

  // ==========================================================
  // Shaft movement
  initial begin
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
  end

  // One pin moves per step, as on a real shaft; gap gives a slow shaft
  task automatic step(input logic rev, input int gap);
    @(posedge i_ref_clk);
    if ((o_pin_a == o_pin_b) ^ rev) begin
      o_pin_b <= ~o_pin_b;
    end else begin
      o_pin_a <= ~o_pin_a;
    end
    repeat (gap + 2) @(posedge i_ref_clk);
  endtask : step

  // Direct levels, used when the pins act as trigger sources
  task automatic set_pins(input logic a, input logic b);
    @(posedge i_ref_clk);
    o_pin_a <= a;
    o_pin_b <= b;
    repeat (6) @(posedge i_ref_clk);
  endtask : set_pins

endmodule : tsme_enc_model

`default_nettype wire
